// >>> include/sgc_pkg.sv
package sgc_pkg;
    // Register indices; the bus byte address is four times the index
    localparam logic [7:0] SGC_IDX_MII_STORM_HI  = 8'h06;
    localparam logic [7:0] SGC_IDX_STORM_LO      = 8'h07;
    localparam logic [7:0] SGC_IDX_FACTORY_A     = 8'h08;
    localparam logic [7:0] SGC_IDX_FACTORY_B     = 8'h09;
    localparam logic [7:0] SGC_IDX_FACTORY_C     = 8'h0a;
    localparam logic [7:0] SGC_IDX_CLK_LED       = 8'h0b;
    localparam logic [7:0] SGC_IDX_PRIO_LOW      = 8'h0c;
    localparam logic [7:0] SGC_IDX_PRIO_HIGH     = 8'h0d;
    localparam logic [7:0] SGC_IDX_STORM_STATUS  = 8'h20;
    localparam int         SGC_ADDR_W            = 8;

    // Field positions
    localparam int SGC_BIT_HALF_DUPLEX = 6;
    localparam int SGC_BIT_FLOW_CTRL   = 5;
    localparam int SGC_BIT_SPEED_10    = 4;
    localparam int SGC_BIT_NULL_VID    = 3;
    localparam int SGC_BIT_LED_MODE    = 1;

    // Reset values
    localparam logic [7:0] SGC_RST_MII_STORM_HI = 8'h20;
    localparam logic [7:0] SGC_RST_STORM_LO     = 8'h63;
    localparam logic [7:0] SGC_RST_FACTORY_A    = 8'h00;
    localparam logic [7:0] SGC_RST_FACTORY_B    = 8'h24;
    localparam logic [7:0] SGC_RST_FACTORY_C    = 8'h35;
    localparam logic [7:0] SGC_RST_CLK_LED      = 8'h8a;
    localparam logic [7:0] SGC_RST_PRIO_LOW     = 8'h50;
    localparam logic [7:0] SGC_RST_PRIO_HIGH    = 8'hfa;

    // Storm interval timing
    localparam longint SGC_CLK_HZ         = 250000000;
    localparam longint SGC_INTERVAL100_MS = 67;
    localparam longint SGC_INTERVAL10_MS  = 500;
    localparam longint SGC_INTERVAL100_CYC = SGC_CLK_HZ * SGC_INTERVAL100_MS / 1000;
    localparam longint SGC_INTERVAL10_CYC  = SGC_CLK_HZ * SGC_INTERVAL10_MS / 1000;
    localparam int     SGC_BLOCK_BYTES     = 64;
    localparam int     SGC_THRESH_W        = 11;

    typedef enum logic [1:0] {
        SGC_CORE_31M  = 2'b00,
        SGC_CORE_62M  = 2'b01,
        SGC_CORE_125M = 2'b10
    } sgc_core_clk_e;
endpackage

// >>> rtl/sgc_storm_port.sv
`timescale 1ns/100ps
// Per-port broadcast storm meter: counts 64-byte blocks per interval
module sgc_storm_port
    import sgc_pkg::*;
#(
    parameter longint INTERVAL100 = SGC_INTERVAL100_CYC,
    parameter longint INTERVAL10  = SGC_INTERVAL10_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    speed10,
    input  wire logic [SGC_THRESH_W-1:0] threshold,
    input  wire logic                    bcastFrameStart,
    input  wire logic                    bcastBlock,
    output logic                         bcastDrop,
    output logic                         limitReached
);
    localparam int CNT_W = 32;
    logic [CNT_W-1:0] intervalCnt;
    logic [CNT_W-1:0] intervalLast;
    logic [SGC_THRESH_W-1:0] blockCnt;
    logic             intervalEnd;
    logic             dropFrame;

    assign intervalLast = speed10 ? CNT_W'(INTERVAL10 - 1) : CNT_W'(INTERVAL100 - 1);
    assign intervalEnd  = intervalCnt >= intervalLast;
    assign limitReached = blockCnt >= threshold;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intervalCnt <= '0;
        end else if (intervalEnd) begin
            intervalCnt <= '0;
        end else begin
            intervalCnt <= intervalCnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blockCnt <= '0;
        end else if (intervalEnd) begin
            blockCnt <= '0;
        end else if (bcastBlock && !limitReached && !dropFrame) begin
            blockCnt <= blockCnt + SGC_THRESH_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dropFrame <= 1'b0;
        end else if (intervalEnd) begin
            dropFrame <= 1'b0;
        end else if (bcastFrameStart) begin
            dropFrame <= limitReached;
        end
    end

    assign bcastDrop = (bcastFrameStart && limitReached) || (dropFrame && !bcastFrameStart);
endmodule // sgc_storm_port

// >>> rtl/sgc_global_cfg.sv
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
module sgc_global_cfg
    import sgc_pkg::*;
#(
    parameter int     NUM_PORTS   = 3,
    parameter longint INTERVAL100 = SGC_INTERVAL100_CYC,
    parameter longint INTERVAL10  = SGC_INTERVAL10_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Avalon-MM slave, word addressed by byte address
    input  wire logic [9:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // Processor-side MII port controls
    output logic                      miiHalfDuplex,
    output logic                      miiFlowCtrl,
    output logic                      miiSpeed10,
    // Clock selection and LED mode
    output logic      [1:0]           coreClkSel,
    output logic      [1:0]           switchClkSel,
    output logic                      ledModeSelect,
    // Null VID replacement
    input  wire logic [11:0]          vidIn,
    input  wire logic [11:0]          portDefaultVid,
    output logic      [11:0]          vidOut,
    // 802.1p priority lookup
    input  wire logic [2:0]           pcpIn,
    output logic      [1:0]           priorityOut,
    // Broadcast storm per port
    input  wire logic [NUM_PORTS-1:0] portSpeed10,
    input  wire logic [NUM_PORTS-1:0] bcastFrameStart,
    input  wire logic [NUM_PORTS-1:0] bcastBlock,
    output logic      [NUM_PORTS-1:0] bcastDrop
);
    logic [7:0] miiStormHi;
    logic [7:0] stormLo;
    logic [7:0] factoryA;
    logic [7:0] factoryB;
    logic [7:0] factoryC;
    logic [7:0] clkLed;
    logic [7:0] prioLow;
    logic [7:0] prioHigh;
    logic [NUM_PORTS-1:0] limitReached;
    logic [SGC_THRESH_W-1:0] threshold;
    logic [7:0] regIdx;
    logic       wrLane;
    logic       accessPending;
    logic [7:0] next_readByte;
    logic [15:0] prioMap;

    // Decode is word based; the byte address is four times the register index
    assign regIdx = avs_address[9:2];
    // Writes land only at the edge where waitrequest is seen low
    assign wrLane = avs_write && avs_byteenable[0] && accessPending;

    // One wait state per access keeps read data registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accessPending <= 1'b0;
        end else begin
            accessPending <= (avs_read || avs_write) && !accessPending;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !accessPending;

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
        return idx == target;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            miiStormHi <= SGC_RST_MII_STORM_HI;
        end else if (wrLane && hit(regIdx, SGC_IDX_MII_STORM_HI)) begin
            miiStormHi <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stormLo <= SGC_RST_STORM_LO;
        end else if (wrLane && hit(regIdx, SGC_IDX_STORM_LO)) begin
            stormLo <= avs_writedata[7:0];
        end
    end

    // Factory bytes simply store whatever software writes back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            factoryA <= SGC_RST_FACTORY_A;
            factoryB <= SGC_RST_FACTORY_B;
            factoryC <= SGC_RST_FACTORY_C;
        end else if (wrLane) begin
            if (hit(regIdx, SGC_IDX_FACTORY_A)) begin
                factoryA <= avs_writedata[7:0];
            end
            if (hit(regIdx, SGC_IDX_FACTORY_B)) begin
                factoryB <= avs_writedata[7:0];
            end
            if (hit(regIdx, SGC_IDX_FACTORY_C)) begin
                factoryC <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkLed <= SGC_RST_CLK_LED;
        end else if (wrLane && hit(regIdx, SGC_IDX_CLK_LED)) begin
            clkLed <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prioLow  <= SGC_RST_PRIO_LOW;
            prioHigh <= SGC_RST_PRIO_HIGH;
        end else if (wrLane) begin
            if (hit(regIdx, SGC_IDX_PRIO_LOW)) begin
                prioLow <= avs_writedata[7:0];
            end
            if (hit(regIdx, SGC_IDX_PRIO_HIGH)) begin
                prioHigh <= avs_writedata[7:0];
            end
        end
    end

    // Unmapped indices read as zero
    always_comb begin
        next_readByte = 8'h00;
        unique case (regIdx)
            SGC_IDX_MII_STORM_HI: next_readByte = miiStormHi;
            SGC_IDX_STORM_LO:     next_readByte = stormLo;
            SGC_IDX_FACTORY_A:    next_readByte = factoryA;
            SGC_IDX_FACTORY_B:    next_readByte = factoryB;
            SGC_IDX_FACTORY_C:    next_readByte = factoryC;
            SGC_IDX_CLK_LED:      next_readByte = clkLed;
            SGC_IDX_PRIO_LOW:     next_readByte = prioLow;
            SGC_IDX_PRIO_HIGH:    next_readByte = prioHigh;
            SGC_IDX_STORM_STATUS: next_readByte = 8'(limitReached);
            default:              next_readByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !accessPending) begin
            avs_readdata <= {24'h00_0000, next_readByte};
        end
    end

    assign miiHalfDuplex = miiStormHi[SGC_BIT_HALF_DUPLEX];
    assign miiFlowCtrl   = miiStormHi[SGC_BIT_FLOW_CTRL];
    assign miiSpeed10    = miiStormHi[SGC_BIT_SPEED_10];
    assign coreClkSel    = clkLed[7:6];
    assign switchClkSel  = clkLed[5:4];
    assign ledModeSelect = clkLed[SGC_BIT_LED_MODE];

    assign threshold = {miiStormHi[2:0], stormLo};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vidOut <= 12'h000;
        end else if (miiStormHi[SGC_BIT_NULL_VID] && vidIn == 12'h000) begin
            vidOut <= portDefaultVid;
        end else begin
            vidOut <= vidIn;
        end
    end

    assign prioMap = {prioHigh, prioLow};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            priorityOut <= 2'b00;
        end else begin
            priorityOut <= prioMap[{pcpIn, 1'b0} +: 2];
        end
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : gStorm
            sgc_storm_port #(
                .INTERVAL100 (INTERVAL100),
                .INTERVAL10  (INTERVAL10)
            ) uStorm (
                .clk             (clk),
                .rst             (rst),
                .speed10         (portSpeed10[p]),
                .threshold       (threshold),
                .bcastFrameStart (bcastFrameStart[p]),
                .bcastBlock      (bcastBlock[p]),
                .bcastDrop       (bcastDrop[p]),
                .limitReached    (limitReached[p])
            );
        end
    endgenerate
endmodule // sgc_global_cfg

// >>> tb/sgc_global_cfg_assertions.sv
`timescale 1ns/100ps
module sgc_checker
    import sgc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        miiHalfDuplex,
    input wire logic        miiFlowCtrl,
    input wire logic        miiSpeed10,
    input wire logic [1:0]  coreClkSel,
    input wire logic [11:0] vidIn,
    input wire logic [11:0] vidOut
);
    logic take6;
    logic takeB;
    assign take6 = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[9:2] == SGC_IDX_MII_STORM_HI;
    assign takeB = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[9:2] == SGC_IDX_CLK_LED;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request not held off");
    wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state too long");
    half_duplex_a: assert property (take6 |=> miiHalfDuplex == $past(avs_writedata[6]))
        else $error("duplex mode wrong");
    flow_ctrl_a: assert property (take6 |=> miiFlowCtrl == $past(avs_writedata[5]))
        else $error("flow control wrong");
    speed_sel_a: assert property (take6 |=> miiSpeed10 == $past(avs_writedata[4]))
        else $error("speed wrong");
    core_clk_a: assert property (takeB |=> coreClkSel == $past(avs_writedata[7:6]))
        else $error("core clock select wrong");
    vid_pass_a: assert property (vidIn != 12'h000 |=> vidOut == $past(vidIn))
        else $error("nonzero vid altered");
    reset_cfg_a: assert property ($fell(rst) |-> miiFlowCtrl && !miiHalfDuplex && !miiSpeed10 && coreClkSel == 2'h2)
        else $error("reset configuration wrong");
    cover property (take6);
    cover property (takeB);
    cover property (avs_read && !avs_waitrequest);
endmodule // sgc_checker
bind sgc_global_cfg sgc_checker chk_u (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_waitrequest, .miiHalfDuplex, .miiFlowCtrl, .miiSpeed10, .coreClkSel, .vidIn, .vidOut);

// >>> tb/tb_sgc_global_cfg.sv
`timescale 1ns/100ps
module tb_sgc_global_cfg
    import sgc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  addr = 10'h000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hf;
    logic [31:0] rdata, rdVal;
    logic        waitReq, half, flow, spd10, led;
    logic [1:0]  coreSel, swSel, prio;
    logic [11:0] vidIn = 12'h000, defVid = 12'habc, vidOut;
    logic [2:0]  pcp = 3'h0, spd = 3'h0, fStart = 3'h0, blk = 3'h0, drop;
    logic [7:0]  rstTab [8] = '{8'h20, 8'h63, 8'h00, 8'h24, 8'h35, 8'h8a, 8'h50, 8'hfa};
    int          failures = 0, total_checks = 0, n;

    sgc_global_cfg #(.INTERVAL100(100), .INTERVAL10(200)) dut_u (.clk(clk), .rst(rst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitReq), .miiHalfDuplex(half), .miiFlowCtrl(flow), .miiSpeed10(spd10),
        .coreClkSel(coreSel), .switchClkSel(swSel), .ledModeSelect(led), .vidIn(vidIn),
        .portDefaultVid(defVid), .vidOut(vidOut), .pcpIn(pcp), .priorityOut(prio), .portSpeed10(spd),
        .bcastFrameStart(fStart), .bcastBlock(blk), .bcastDrop(drop));

    always #2 clk = ~clk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic access(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] b);
        int k;
        k = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        be <= b;
        @(posedge clk);
        while (waitReq !== 1'b0) begin
            k++;
            @(posedge clk);
        end
        rdVal = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        check("wait states", k, 32'h1);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        access(1'b0, idx, 8'h00, 4'hf);
        check("readdata", rdVal, exp);
    endtask

    task automatic prioCheck(input logic [15:0] map);
        for (int p = 0; p < 8; p++) begin
            @(posedge clk);
            pcp <= p[2:0];
            @(posedge clk);
            @(negedge clk);
            check("priority", prio, map[2*p +: 2]);
        end
    endtask

    task automatic vidCheck(input logic [11:0] v, input logic [11:0] exp);
        @(posedge clk);
        vidIn <= v;
        @(posedge clk);
        @(negedge clk);
        check("vid", vidOut, exp);
    endtask

    task automatic pulse(input logic [2:0] s, input logic [2:0] b);
        @(posedge clk);
        fStart <= s;
        blk <= b;
        @(posedge clk);
        fStart <= 3'h0;
        blk <= 3'h0;
    endtask

    task automatic pollClear(input int b);
        n = 0;
        do begin access(1'b0, 8'h20, 8'h00, 4'hf); n++; end while (rdVal[b] !== 1'b0 && n < 100);
    endtask

    // Reach the limit once, then wait for the restart so counting begins at an interval start
    task automatic align(input logic [2:0] m, input int b);
        int t;
        t = 0;
        do begin
            repeat (3) pulse(3'h0, m);
            access(1'b0, 8'h20, 8'h00, 4'hf);
            t++;
        end while (rdVal[b] !== 1'b1 && t < 4);
        pollClear(b);
    endtask

    task automatic close_out;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rchk(8'h06 + i[7:0], {24'h0, rstTab[i]});
        check("mii", {half, flow, spd10}, 3'b010);
        check("clocks", {coreSel, swSel, led}, 5'b10001);
        prioCheck(16'hfa50);
        access(1'b1, 8'h06, 8'h5d, 4'hf);
        @(negedge clk);
        check("mii", {half, flow, spd10}, 3'b101);
        rchk(8'h06, 32'h5d);
        // Byte lane 0 disabled and unmapped index must both leave state alone
        access(1'b1, 8'h06, 8'h00, 4'he);
        rchk(8'h06, 32'h5d);
        access(1'b1, 8'h30, 8'hff, 4'hf);
        rchk(8'h30, 32'h0);
        vidCheck(12'h000, 12'habc);
        @(posedge clk);
        defVid <= 12'h123;
        vidCheck(12'h000, 12'h123);
        vidCheck(12'h005, 12'h005);
        access(1'b1, 8'h06, 8'h20, 4'hf);
        vidCheck(12'h000, 12'h000);
        for (int c = 0; c < 3; c++) begin
            access(1'b1, 8'h0b, {c[1:0], 6'h1a}, 4'hf);
            @(negedge clk);
            check("clocks", {coreSel, swSel}, {c[1:0], 2'b01});
        end
        access(1'b1, 8'h0c, 8'h1b, 4'hf);
        access(1'b1, 8'h0d, 8'he4, 4'hf);
        prioCheck(16'he41b);
        // Threshold of 3 blocks; align each meter to an interval start before counting
        access(1'b1, 8'h07, 8'h03, 4'hf);
        align(3'h1, 0);
        repeat (3) pulse(3'h0, 3'h1);
        rchk(8'h20, 32'h1);
        @(posedge clk);
        fStart <= 3'h1;
        @(negedge clk);
        check("drop", drop, 3'h1);
        @(posedge clk);
        fStart <= 3'h0;
        @(negedge clk);
        check("drop held", drop, 3'h1);
        pollClear(0);
        check("interval", {31'h0, n > 20 && n < 40}, 32'h1);
        @(posedge clk);
        fStart <= 3'h1;
        @(negedge clk);
        check("drop", drop, 3'h0);
        @(posedge clk);
        fStart <= 3'h0;
        // Port 1 at 10 Mb/s runs on the longer interval
        spd <= 3'h2;
        align(3'h2, 1);
        repeat (3) pulse(3'h0, 3'h2);
        pollClear(1);
        check("interval 10M", {31'h0, n > 50 && n < 75}, 32'h1);
        close_out();
    end
endmodule // tb_sgc_global_cfg
